// ===== pkg/pex_cfg.svh
`ifndef PEX_CFG_SVH
`define PEX_CFG_SVH
// Clock and timing
`define PEX_CLK_HZ 25'h17D_7840
`define PEX_CLK_NS 21'h00_0028
`define PEX_DWELL_UNIT_NS 32'h000F_4240
`define PEX_DWELL_CYC (`PEX_DWELL_UNIT_NS / 32'h0000_0028)
`define PEX_DEC_SCALE 64'h0000_0000_7735_9400
// Reset values
`define PEX_POS_RST 24'h00_0000
`define PEX_SPD_RST 20'h0_03E8
`define PEX_ACC_RST 20'h0_03E8
`define PEX_PUSH_RST 10'h0C8
`define PEX_FULL_CUR 10'h3E8
`define PEX_START_RST 20'h0_01F4
// Address map, field and register word indices
`define PEX_CTRL_SEL 1'h1
`define PEX_F_POS 3'h0
`define PEX_F_SPD 3'h1
`define PEX_F_ACC 3'h2
`define PEX_F_DEC 3'h3
`define PEX_F_FLAG 3'h4
`define PEX_F_DWELL 3'h5
`define PEX_F_PUSH 3'h6
`define PEX_R_CTRL 9'h000
`define PEX_R_START 9'h001
`define PEX_R_CACC 9'h002
`define PEX_R_CDEC 9'h003
`define PEX_R_STAT 9'h004
`define PEX_R_CPOS 9'h005
`define PEX_R_DEST 9'h006
// Flag word fields
`define PEX_FL_ABS 0
`define PEX_FL_FUNC_LO 1
`define PEX_FL_FUNC_HI 2
`define PEX_FL_SEQ 3
`endif

// ===== pkg/pex_pkg.sv
package pex_pkg;
   typedef enum logic [1:0] {
      PEX_FN_SINGLE,
      PEX_FN_LINKED,
      PEX_FN_LINKED_DWELL,
      PEX_FN_PUSH
   } pex_func_t;
   typedef enum logic [1:0] {
      PEX_ST_IDLE,
      PEX_ST_RUN,
      PEX_ST_DWELL
   } pex_state_t;
endpackage

// ===== rtl/pex_executor.sv
// Contract
// - Sixty-four entries, indices 0 to 63, each with full parameters.
// - Target position is signed 24-bit steps, reset to zero.
// - Running speed 0 to 1,000,000 Hz, reached and held in the move.
// - Acceleration 1 to 1,000,000, 0.001 ms/kHz units, reset 1000.
// - Deceleration same range and unit, reset 1000.
// - Addressing bit: 0 relative, 1 absolute, reset relative.
// - Function: 0 single, 1 linked, 2 linked with pause, 3 push.
// - Pause 0 to 50000 ms, used only by linked-with-pause.
// - Push current 0 to 1000 in 0.1 %, reset 200, limits pushing.
// - Per-entry sequential enable, reset 0, allows step-in from prior.
// - Start at starting speed, ramp up, hold, ramp down, stop on target.
// - Separate ramp source uses the entry's own ramp values.
// - Common ramp source uses one shared accel and decel value; the code keeps two, cacc_q for accel and cdec_q for decel.
// - Absolute: destination is entry position measured from home.
// - Relative: destination is previous destination plus position.
// - Single move runs the selected entry only, then finishes.
// - Linked runs straight into the next entry without stopping.
// - Linked-with-pause stops, waits the pause, runs the next entry.
// - Push keeps driving toward target under push current limit.
// - Host waits ready, selects, starts; ready drops then returns.
// - Sequential step runs next entry, or returns to chain start.
`timescale 1ns/100ps
`default_nettype none
`include "pex_cfg.svh"
module pex_executor (
   input wire logic i_clk,
   input wire logic i_rstn,
   // Wishbone classic slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [11:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Host controller
   input wire logic [5:0] i_entry_select_inputs,
   input wire logic i_start,
   input wire logic i_sequential_step_input,
   output logic o_ready,
   // Power stage
   output logic o_step,
   output logic o_dir,
   output logic [9:0] o_current_limit,
   output logic o_pushing,
   output logic [5:0] o_entry
);
   import pex_pkg::*;

   // ----------------------------------------------------------------
   // Entry table
   // ----------------------------------------------------------------
   logic [23:0] pos_q [64];
   logic [19:0] spd_q [64];
   logic [19:0] acc_q [64];
   logic [19:0] dec_q [64];
   logic [63:0] abs_q;
   logic [1:0] func_q [64];
   logic [63:0] seq_en_q;
   logic [15:0] dwell_q [64];
   logic [9:0] push_q [64];
   logic ramp_common_q;
   logic [19:0] start_spd_q;
   logic [19:0] cacc_q;
   logic [19:0] cdec_q;

   logic ack_q;
   logic [31:0] rdat_q;
   logic wr_en;
   logic is_ctrl;
   logic [5:0] w_idx;
   logic [2:0] w_fld;
   logic [8:0] w_reg;
   logic [31:0] wmask;
   logic [31:0] wdat;

   // Motion state
   pex_state_t state_q;
   logic [5:0] idx_q;
   logic signed [31:0] cur_q;
   logic signed [31:0] dest_q;
   logic [19:0] speed_q;
   logic [24:0] phase_q;
   logic [20:0] ramp_q;
   logic [31:0] dwell_cnt_q;
   logic [5:0] origin_q;
   logic [5:0] seq_ptr_q;
   logic start_prev_q;
   logic seq_prev_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign is_ctrl = (i_wb_adr[11] == `PEX_CTRL_SEL);
   assign w_idx = i_wb_adr[10:5];
   assign w_fld = i_wb_adr[4:2];
   assign w_reg = i_wb_adr[10:2];
   assign wr_en = i_wb_cyc & i_wb_stb & i_wb_we & ack_q;
   assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                   {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

   // Merge byte lanes into the currently read word
   always_comb begin
      wdat = (i_wb_dat & wmask) | (rdat_q & ~wmask);
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= i_wb_cyc & i_wb_stb & ~ack_q;
      end
   end

   // Entry writes; reset defaults
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int i = 0; i < 64; i++) begin
            pos_q[i] <= `PEX_POS_RST;
            spd_q[i] <= `PEX_SPD_RST;
            acc_q[i] <= `PEX_ACC_RST;
            dec_q[i] <= `PEX_ACC_RST;
            func_q[i] <= PEX_FN_SINGLE;
            dwell_q[i] <= 16'h0000;
            push_q[i] <= `PEX_PUSH_RST;
         end
         abs_q <= 64'h0000_0000_0000_0000;
         seq_en_q <= 64'h0000_0000_0000_0000;
      end else if (wr_en && !is_ctrl) begin
         unique case (w_fld)
            `PEX_F_POS: pos_q[w_idx] <= wdat[23:0];
            `PEX_F_SPD: spd_q[w_idx] <= wdat[19:0];
            `PEX_F_ACC: acc_q[w_idx] <= wdat[19:0];
            `PEX_F_DEC: dec_q[w_idx] <= wdat[19:0];
            `PEX_F_FLAG: begin
               abs_q[w_idx] <= wdat[`PEX_FL_ABS];
               func_q[w_idx] <= wdat[`PEX_FL_FUNC_HI:`PEX_FL_FUNC_LO];
               seq_en_q[w_idx] <= wdat[`PEX_FL_SEQ];
            end
            `PEX_F_DWELL: dwell_q[w_idx] <= wdat[15:0];
            `PEX_F_PUSH: push_q[w_idx] <= wdat[9:0];
            default: ;
         endcase
      end
   end

   // Control registers
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ramp_common_q <= 1'b0;
         start_spd_q <= `PEX_START_RST;
         cacc_q <= `PEX_ACC_RST;
         cdec_q <= `PEX_ACC_RST;
      end else if (wr_en && is_ctrl) begin
         unique case (w_reg)
            `PEX_R_CTRL: ramp_common_q <= wdat[0];
            `PEX_R_START: start_spd_q <= wdat[19:0];
            `PEX_R_CACC: cacc_q <= wdat[19:0];
            `PEX_R_CDEC: cdec_q <= wdat[19:0];
            default: ;
         endcase
      end
   end

   // Read data, valid with ack
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdat_q <= 32'h0000_0000;
      end else if (!ack_q) begin
         rdat_q <= 32'h0000_0000;
         if (!is_ctrl) begin
            unique case (w_fld)
               `PEX_F_POS: rdat_q <= {{8{pos_q[w_idx][23]}},
                                      pos_q[w_idx]};
               `PEX_F_SPD: rdat_q[19:0] <= spd_q[w_idx];
               `PEX_F_ACC: rdat_q[19:0] <= acc_q[w_idx];
               `PEX_F_DEC: rdat_q[19:0] <= dec_q[w_idx];
               `PEX_F_FLAG: rdat_q[3:0] <= {seq_en_q[w_idx],
                                            func_q[w_idx], abs_q[w_idx]};
               `PEX_F_DWELL: rdat_q[15:0] <= dwell_q[w_idx];
               `PEX_F_PUSH: rdat_q[9:0] <= push_q[w_idx];
               default: ;
            endcase
         end else begin
            unique case (w_reg)
               `PEX_R_CTRL: rdat_q[0] <= ramp_common_q;
               `PEX_R_START: rdat_q[19:0] <= start_spd_q;
               `PEX_R_CACC: rdat_q[19:0] <= cacc_q;
               `PEX_R_CDEC: rdat_q[19:0] <= cdec_q;
               `PEX_R_STAT: rdat_q[13:0] <= {idx_q, 6'h00,
                                             o_pushing, o_ready};
               `PEX_R_CPOS: rdat_q <= cur_q;
               `PEX_R_DEST: rdat_q <= dest_q;
               default: ;
            endcase
         end
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;

   // ----------------------------------------------------------------
   // Launch and chaining decisions
   // ----------------------------------------------------------------
   logic start_edge;
   logic seq_edge;
   logic launch;
   logic [5:0] seq_pick;
   logic [5:0] launch_idx;
   logic [5:0] next_idx;
   logic [5:0] load_idx;
   logic load;
   logic signed [31:0] load_dest;
   logic signed [31:0] load_pos;

   assign start_edge = i_start & ~start_prev_q;
   assign seq_edge = i_sequential_step_input & ~seq_prev_q;
   assign launch = state_q == PEX_ST_IDLE & (start_edge | seq_edge);
   assign seq_pick = seq_en_q[seq_ptr_q] ? seq_ptr_q : origin_q;
   assign launch_idx = start_edge ? i_entry_select_inputs : seq_pick;
   assign next_idx = idx_q + 6'h01;

   // ----------------------------------------------------------------
   // Profile arithmetic
   // ----------------------------------------------------------------
   logic [19:0] vmin;
   logic [19:0] vrun;
   logic flat;
   logic [19:0] acc_rate;
   logic [19:0] dec_rate;
   logic [31:0] rem;
   logic at_target;
   logic [39:0] vsq;
   logic [39:0] vmsq;
   logic [63:0] stop_lhs;
   logic [63:0] stop_rhs;
   logic want_dec;
   logic [19:0] tgt_spd;
   logic [20:0] ramp_nxt;
   logic [24:0] phase_nxt;
   logic step_now;
   logic pex_linked;

   assign vmin = (start_spd_q == 20'h0_0000) ? 20'h0_0001 : start_spd_q;
   assign vrun = (spd_q[idx_q] == 20'h0_0000) ? 20'h0_0001 : spd_q[idx_q];
   assign flat = (start_spd_q >= spd_q[idx_q]);
   assign acc_rate = ramp_common_q ? cacc_q : acc_q[idx_q];
   assign dec_rate = ramp_common_q ? cdec_q : dec_q[idx_q];
   assign rem = (dest_q > cur_q) ? 32'(dest_q - cur_q)
                                 : 32'(cur_q - dest_q);
   assign at_target = (rem == 32'h0000_0000);
   assign vsq = 40'(speed_q) * 40'(speed_q);
   assign vmsq = 40'(vmin) * 40'(vmin);
   assign stop_lhs = (vsq > vmsq) ? 64'(vsq - vmsq) * 64'(dec_rate)
                                  : 64'h0000_0000_0000_0000;
   assign stop_rhs = 64'(rem) * `PEX_DEC_SCALE;
   assign pex_linked = (func_q[idx_q] == PEX_FN_LINKED);
   // Linked entries hand their speed to the next one
   assign want_dec = ~pex_linked & (stop_lhs >= stop_rhs);
   always_comb begin
      tgt_spd = vrun;
      if (!flat && want_dec) begin
         tgt_spd = vmin;
      end
   end
   assign ramp_nxt = ramp_q + `PEX_CLK_NS;
   assign phase_nxt = phase_q + 25'(speed_q);
   assign step_now = (phase_nxt >= `PEX_CLK_HZ) & ~at_target;

   // Next entry load, absolute or relative
   assign load = launch | ((state_q == PEX_ST_RUN) & at_target &
                           pex_linked) |
                 ((state_q == PEX_ST_DWELL) &
                  (dwell_cnt_q == 32'h0000_0000));
   assign load_idx = launch ? launch_idx : next_idx;
   assign load_pos = 32'(signed'(pos_q[load_idx]));
   assign load_dest = abs_q[load_idx] ? load_pos
                                      : dest_q + load_pos;

   // ----------------------------------------------------------------
   // Input edges and sequence pointer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         start_prev_q <= 1'b0;
         seq_prev_q <= 1'b0;
      end else begin
         start_prev_q <= i_start;
         seq_prev_q <= i_sequential_step_input;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         origin_q <= 6'h00;
         seq_ptr_q <= 6'h00;
      end else if (launch) begin
         if (start_edge) begin
            origin_q <= i_entry_select_inputs;
         end
         seq_ptr_q <= launch_idx + 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // Motion sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= PEX_ST_IDLE;
         idx_q <= 6'h00;
         dest_q <= 32'h0000_0000;
         dwell_cnt_q <= 32'h0000_0000;
      end else begin
         if (load) begin
            idx_q <= load_idx;
            dest_q <= load_dest;
         end
         unique case (state_q)
            PEX_ST_IDLE: begin
               if (launch) begin
                  state_q <= PEX_ST_RUN;
               end
            end
            PEX_ST_RUN: begin
               if (at_target) begin
                  unique case (func_q[idx_q])
                     PEX_FN_LINKED: state_q <= PEX_ST_RUN;
                     PEX_FN_LINKED_DWELL: begin
                        state_q <= PEX_ST_DWELL;
                        dwell_cnt_q <= 32'(dwell_q[idx_q]) *
                                       `PEX_DWELL_CYC;
                     end
                     default: state_q <= PEX_ST_IDLE;
                  endcase
               end
            end
            PEX_ST_DWELL: begin
               if (dwell_cnt_q == 32'h0000_0000) begin
                  state_q <= PEX_ST_RUN;
               end else begin
                  dwell_cnt_q <= dwell_cnt_q - 32'h0000_0001;
               end
            end
            default: state_q <= PEX_ST_IDLE;
         endcase
      end
   end

   // Speed ramp and step generation
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         speed_q <= `PEX_START_RST;
         phase_q <= 25'h000_0000;
         ramp_q <= 21'h00_0000;
         cur_q <= 32'h0000_0000;
         o_step <= 1'b0;
         o_dir <= 1'b0;
      end else begin
         o_step <= 1'b0;
         if (state_q != PEX_ST_RUN) begin
            speed_q <= flat ? vrun : vmin;
            phase_q <= 25'h000_0000;
            ramp_q <= 21'h00_0000;
         end else if (!at_target) begin
            o_dir <= (dest_q > cur_q);
            if (step_now) begin
               phase_q <= phase_nxt - `PEX_CLK_HZ;
               o_step <= 1'b1;
               cur_q <= (dest_q > cur_q) ? cur_q + 32'sh0000_0001
                                         : cur_q - 32'sh0000_0001;
            end else begin
               phase_q <= phase_nxt;
            end
            if (flat) begin
               speed_q <= vrun;
               ramp_q <= 21'h00_0000;
            end else if (speed_q < tgt_spd) begin
               if (ramp_nxt >= 21'(acc_rate)) begin
                  speed_q <= speed_q + 20'h0_0001;
                  ramp_q <= ramp_nxt - 21'(acc_rate);
               end else begin
                  ramp_q <= ramp_nxt;
               end
            end else if (speed_q > tgt_spd) begin
               if (ramp_nxt >= 21'(dec_rate)) begin
                  speed_q <= speed_q - 20'h0_0001;
                  ramp_q <= ramp_nxt - 21'(dec_rate);
               end else begin
                  ramp_q <= ramp_nxt;
               end
            end else begin
               ramp_q <= 21'h00_0000;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Host and power stage outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_ready <= 1'b1;
         o_pushing <= 1'b0;
         o_current_limit <= `PEX_FULL_CUR;
         o_entry <= 6'h00;
      end else begin
         // Ready returns only when the whole chain is idle
         o_ready <= (state_q == PEX_ST_IDLE) & ~launch;
         o_entry <= load ? load_idx : idx_q;
         if (load) begin
            // Push holds its limit after contact until the next move
            o_pushing <= (func_q[load_idx] == PEX_FN_PUSH);
            o_current_limit <= (func_q[load_idx] == PEX_FN_PUSH) ?
                               push_q[load_idx] : `PEX_FULL_CUR;
         end
      end
   end

endmodule
`default_nettype wire

// ===== tb/pex_executor_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module pex_chk (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic o_wb_ack,
   input wire logic [5:0] i_entry_select_inputs,
   input wire logic i_start,
   input wire logic i_sequential_step_input,
   input wire logic o_ready,
   input wire logic o_step,
   input wire logic [9:0] o_current_limit,
   input wire logic o_pushing,
   input wire logic [5:0] o_entry
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   a_ack_answers: assert property (
      i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("bus request not answered");
   a_start_busy: assert property (
      o_ready && $rose(i_start) |=> !o_ready)
      else $error("ready stayed high after start");
   a_seq_busy: assert property (
      o_ready && $rose(i_sequential_step_input) |=> !o_ready)
      else $error("ready stayed high after step input");
   a_entry_taken: assert property (
      o_ready && $rose(i_start) |=> o_entry == $past(i_entry_select_inputs))
      else $error("entry differs from selection");
   a_ready_hold: assert property (
      o_ready && !$rose(i_start) && !$rose(i_sequential_step_input)
      |=> o_ready)
      else $error("ready fell without a start");
   a_entry_idle: assert property (
      o_ready && !$rose(i_start) && !$rose(i_sequential_step_input)
      |=> $stable(o_entry))
      else $error("entry changed while idle");
   a_no_step_idle: assert property (o_ready |-> !o_step)
      else $error("step while ready");
   a_step_rate: assert property (o_step |=> !o_step [*8])
      else $error("steps faster than top rate");
   a_full_current: assert property (
      !o_pushing |-> o_current_limit == 10'h3E8)
      else $error("limit reduced outside push");
endmodule
bind pex_executor pex_chk chk (
   .i_clk(i_clk),
   .i_rstn(i_rstn),
   .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb),
   .o_wb_ack(o_wb_ack),
   .i_entry_select_inputs(i_entry_select_inputs),
   .i_start(i_start),
   .i_sequential_step_input(i_sequential_step_input),
   .o_ready(o_ready),
   .o_step(o_step),
   .o_current_limit(o_current_limit),
   .o_pushing(o_pushing),
   .o_entry(o_entry)
);
`default_nettype wire

// ===== tb/pex_executor_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pex_executor_tb_top;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack, ready, step, dir, pushing, start, seq;
   logic [9:0] limit;
   logic [5:0] hsel, entry;
   logic [31:0] pos_cnt = 32'h0000_0000;
   logic [31:0] exp_q[$];
   int miscompares = 0;
   int n_tests = 0;
   int n;
   always #20 i_clk = ~i_clk;
   pex_executor uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_entry_select_inputs(hsel), .i_start(start),
      .i_sequential_step_input(seq), .o_ready(ready), .o_step(step),
      .o_dir(dir), .o_current_limit(limit), .o_pushing(pushing),
      .o_entry(entry));
   pex_host_model host (.i_clk(i_clk), .i_ready(ready), .o_select(hsel),
      .o_start(start), .o_seq(seq));
   // ----------
   // Helpers
   // ----------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge i_clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0000_0000);
   endtask
   function automatic logic [11:0] ea(input logic [5:0] e,
         input logic [2:0] f);
      return {1'b0, e, f, 2'b00};
   endfunction
   task automatic set_entry(input logic [5:0] e, input logic [31:0] p,
         input logic [31:0] fl);
      wb(1'b1, ea(e, 3'h0), p);
      wb(1'b1, ea(e, 3'h1), 32'h000F_4240);
      wb(1'b1, ea(e, 3'h4), fl);
   endtask
   task automatic mv(input logic [5:0] e, input logic sq, input logic [31:0] d,
         input logic [5:0] ent);
      host.run(e, sq, $urandom_range(3, 0));
      check(pos_cnt, d);
      check({26'h000_0000, entry}, {26'h000_0000, ent});
      rd(12'h814, d);
      rd(12'h818, d);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----------
   // Monitor
   // ----------
   always @(posedge i_clk) begin
      if (ack === 1'b1 && we === 1'b0)
         check(rdat, exp_q.pop_front());
      if (step === 1'b1)
         pos_cnt <= dir ? pos_cnt + 32'h0000_0001 : pos_cnt - 32'h0000_0001;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      miscompares++;
      tally_and_finish();
   end
   // ----------
   // Tests
   // ----------
   initial begin
      logic [5:0] e;
      n = $urandom(32'h39b3_ee8a);
      repeat (8) @(posedge i_clk);
      i_rstn <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         e = k ? 6'h3F : 6'h00;
         rd(ea(e, 3'h0), 32'h0000_0000);
         rd(ea(e, 3'h1), 32'h0000_03E8);
         rd(ea(e, 3'h2), 32'h0000_03E8);
         rd(ea(e, 3'h3), 32'h0000_03E8);
         rd(ea(e, 3'h4), 32'h0000_0000);
         rd(ea(e, 3'h5), 32'h0000_0000);
         rd(ea(e, 3'h6), 32'h0000_00C8);
      end
      rd(12'h808, 32'h0000_03E8);
      rd(12'h810, 32'h0000_0001);
      done("reset values");
      wb(1'b1, ea(6'h05, 3'h0), 32'h0080_0000);
      rd(ea(6'h05, 3'h0), 32'hFF80_0000);
      wb(1'b1, ea(6'h05, 3'h0), 32'h007F_FFFF);
      rd(ea(6'h05, 3'h0), 32'h007F_FFFF);
      wb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
      rd(12'hFFC, 32'h0000_0000);
      wb(1'b1, 12'h800, 32'h0000_0001);
      rd(12'h800, 32'h0000_0001);
      done("registers");
      wb(1'b1, 12'h804, 32'h000F_4240);
      n = $urandom_range(4, 1);
      set_entry(6'h01, 32'(n), 32'h0000_0000);
      mv(6'h01, 1'b0, 32'(n), 6'h01);
      mv(6'h01, 1'b0, 32'(2 * n), 6'h01);
      set_entry(6'h02, 32'hFFFF_FFFE, 32'h0000_0001);
      mv(6'h02, 1'b0, 32'hFFFF_FFFE, 6'h02);
      done("addressing");
      set_entry(6'h03, 32'h0000_0002, 32'h0000_0002);
      set_entry(6'h04, 32'h0000_0003, 32'h0000_0000);
      mv(6'h03, 1'b0, 32'h0000_0003, 6'h04);
      set_entry(6'h05, 32'h0000_0002, 32'h0000_0004);
      set_entry(6'h06, 32'hFFFF_FFFC, 32'h0000_0000);
      mv(6'h05, 1'b0, 32'h0000_0001, 6'h06);
      done("chains");
      set_entry(6'h07, 32'h0000_0002, 32'h0000_0006);
      wb(1'b1, ea(6'h07, 3'h6), 32'h0000_012C);
      mv(6'h07, 1'b0, 32'h0000_0003, 6'h07);
      check({22'h00_0000, limit}, 32'h0000_012C);
      rd(12'h810, 32'h0000_0703);
      mv(6'h01, 1'b0, 32'(3 + n), 6'h01);
      check({22'h00_0000, limit}, 32'h0000_03E8);
      done("push");
      set_entry(6'h08, 32'h0000_0001, 32'h0000_0000);
      set_entry(6'h09, 32'h0000_0001, 32'h0000_0008);
      set_entry(6'h0A, 32'h0000_0001, 32'h0000_0000);
      mv(6'h08, 1'b0, 32'(4 + n), 6'h08);
      mv(6'h08, 1'b1, 32'(5 + n), 6'h09);
      mv(6'h08, 1'b1, 32'(6 + n), 6'h08);
      done("sequential");
      // Start speed below run speed: ramped moves, common then own ramps
      wb(1'b1, 12'h804, 32'h000D_BBA0);
      mv(6'h01, 1'b0, 32'(6 + 2 * n), 6'h01);
      wb(1'b1, 12'h800, 32'h0000_0000);
      rd(12'h800, 32'h0000_0000);
      mv(6'h01, 1'b0, 32'(6 + 3 * n), 6'h01);
      done("ramps");
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ===== tb/pex_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pex_host_model (
   input wire logic i_clk,
   input wire logic i_ready,
   output logic [5:0] o_select = 6'h00,
   output logic o_start = 1'b0,
   output logic o_seq = 1'b0
);
   // ----------
   // Host move
   // ----------
   task automatic run(input logic [5:0] sel, input logic sq, input int gap);
      while (i_ready !== 1'b1) @(posedge i_clk);
      repeat (gap) @(posedge i_clk);
      o_select <= sel;
      @(posedge i_clk);
      if (sq) o_seq <= 1'b1;
      else o_start <= 1'b1;
      do @(posedge i_clk); while (i_ready === 1'b1);
      o_start <= 1'b0;
      o_seq <= 1'b0;
      // Released select no longer shows the index
      o_select <= ~sel;
      do @(posedge i_clk); while (i_ready !== 1'b1);
   endtask
endmodule
`default_nettype wire
